// ===== src/chip_select_ready_unit.sv
// Chip select decode and ready wait-state generator
`timescale 1ns/1ps
`include "csr_unit_map.svh"
module chip_select_ready_unit
  import csr_unit_pkg::*;
#(
  parameter int MID_LOW_BIT = 13
) (
  input wire logic clk, // 100 MHz clock
  input wire logic rst, // Async reset, active high
  input wire logic [2:0] reg_addr, // Register index
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [15:0] reg_rdata, // Read data, cycle after strobe
  input wire bus_cycle_t cyc, // Internal bus cycle info
  input wire logic ext_ready_pin, // External ready, asynchronous
  input wire logic coproc_error_pin, // Coprocessor error, asynchronous
  input wire logic coproc_request_pin, // Coprocessor request, asynchronous
  output logic upper_mem_select_n, // Upper memory select
  output logic lower_mem_select_n, // Lower memory select
  output logic [3:0] midrange_selects_n, // Mid selects / coproc pins
  output logic [6:0] periph_select_n, // Peripheral selects
  output logic coproc_error_seen, // Synchronised coprocessor error
  output logic coproc_request, // Synchronised coprocessor request
  output logic ready_out // Internal ready to bus unit
);

  // ****************************************
  // Synchronisers
  // ****************************************
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
    end else begin
      meta_q <= {ext_ready_pin, coproc_error_pin, coproc_request_pin};
      sync_q <= meta_q;
    end
  end

  // Block mask per 1K granule: ones cover the bottom block, zeros cover the top block
  function automatic logic in_top(input logic [19:0] a,
                                  input logic [15:0] m);
    in_top = ((~a[19:10] & m[`MASK_HI:`MASK_LO]) == 10'h000)
             && (a[19:18] == 2'h3);
  endfunction

  function automatic logic in_bottom(input logic [19:0] a,
                                     input logic [15:0] m);
    in_bottom = ((a[19:10] & ~m[`MASK_HI:`MASK_LO]) == 10'h000)
                && (a[19:18] == 2'h0);
  endfunction

  unit_state_t s_q;
  unit_state_t s_d;

  logic [19:0] a;
  logic [12:0] hit;
  logic [19:0] mid_size;
  logic [19:0] mid_off;
  logic [19:0] pbase;
  logic [19:0] poff;
  logic periph_ok;
  logic mid_ok;
  logic [2:0] rdy_sel;
  logic rd_hit;

  // ****************************************
  // Decode
  // ****************************************
  always_comb begin
    a = cyc.addr;
    hit = 13'h0000;
    rdy_sel = s_q.upper[`RDY_HI:`RDY_LO];
    // Size in bytes from a one-hot 8K-unit field
    mid_size = {s_q.mid_periph[14:8], 13'h0000};
    mid_off = a - {s_q.mid_base[15:9], MID_LOW_BIT'(0)};
    pbase = {s_q.periph_base[15:6], 10'h000};
    poff = a - pbase;
    periph_ok = s_q.pbase_seen && s_q.mperiph_seen;
    mid_ok = s_q.mbase_seen && s_q.mperiph_seen;
    if (cyc.active && !cyc.external) begin
      if (cyc.mem_space && in_top(a, s_q.upper)) begin
        hit[12] = 1'b1;
        rdy_sel = s_q.upper[`RDY_HI:`RDY_LO];
      end
      if (cyc.mem_space && s_q.lower_seen
          && in_bottom(a, s_q.lower)) begin
        hit[11] = 1'b1;
        rdy_sel = s_q.lower[`RDY_HI:`RDY_LO];
      end
      if (cyc.mem_space && mid_ok && mid_size != 20'h00000
          && mid_off < mid_size) begin
        if (mid_off < (mid_size >> 2))
          hit[7] = 1'b1;
        else if (mid_off < (mid_size >> 1))
          hit[8] = 1'b1;
        else if (mid_off < mid_size - (mid_size >> 2))
          hit[9] = 1'b1;
        else
          hit[10] = 1'b1;
        rdy_sel = s_q.mid_base[`RDY_HI:`RDY_LO];
      end
      if (periph_ok && cyc.mem_space == s_q.mid_periph[`MP_MEMSP]
          && poff[19:`PERIPH_SHIFT] < 13'h0007) begin
        hit[poff[9:`PERIPH_SHIFT]] = 1'b1;
        rdy_sel = s_q.periph_base[`RDY_HI:`RDY_LO];
      end
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    rd_hit = reg_rd;
    s_d.rdata = 16'h0000;
    if (reg_wr || rd_hit) begin
      case (reg_addr)
        `REG_LOWER: s_d.lower_seen = 1'b1;
        `REG_PERIPH_BASE: s_d.pbase_seen = 1'b1;
        `REG_MID_BASE: s_d.mbase_seen = 1'b1;
        `REG_MID_PERIPH: s_d.mperiph_seen = 1'b1;
        default: ;
      endcase
    end
    if (reg_wr) begin
      case (reg_addr)
        `REG_UPPER: s_d.upper = reg_wdata;
        `REG_LOWER: s_d.lower = reg_wdata;
        `REG_PERIPH_BASE: s_d.periph_base = reg_wdata;
        `REG_MID_BASE: s_d.mid_base = reg_wdata;
        `REG_MID_PERIPH: s_d.mid_periph = reg_wdata;
        `REG_MODE: s_d.enhanced = reg_wdata[`MODE_ENH];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `REG_UPPER: s_d.rdata = s_q.upper;
        `REG_LOWER: s_d.rdata = s_q.lower;
        `REG_PERIPH_BASE: s_d.rdata = s_q.periph_base;
        `REG_MID_BASE: s_d.rdata = s_q.mid_base;
        `REG_MID_PERIPH: s_d.rdata = s_q.mid_periph;
        `REG_MODE: s_d.rdata = {15'h0000, s_q.enhanced};
        default: s_d.rdata = 16'h0000;
      endcase
    end
    // Control block hit: selects released two cycles after start
    s_d.ctrl_hit = cyc.active && !cyc.mem_space
                   && a[19:8] == `CTRL_BLOCK_HI;
    // Select outputs, active low; never floated in hold
    s_d.sel_n = ~hit;
    if (s_q.ctrl_hit && !cyc.start)
      s_d.sel_n = 13'h1FFF;
    // Coprocessor select only on numerics cycles
    if (s_q.enhanced) begin
      s_d.sel_n[10] = !(cyc.active && !cyc.external
                        && cyc.numerics);
      // First two mid pins serve as coprocessor inputs, so kept idle
      s_d.sel_n[8:7] = 2'h3;
    end
    if (cyc.start)
      s_d.addr_lat = a[2:1];
    if (s_q.mid_periph[`MP_OPT] && periph_ok) begin
      s_d.sel_n[5] = cyc.start ? a[1] : s_q.addr_lat[0];
      s_d.sel_n[6] = cyc.start ? a[2] : s_q.addr_lat[1];
    end
    // Ready generation
    s_d.ready = 1'b0;
    case (s_q.st)
      IDLE: begin
        if (cyc.start && hit != 13'h0000) begin
          s_d.rdy_cfg = rdy_sel;
          s_d.wait_cnt = rdy_sel[1:0];
          s_d.st = WAITING;
        end
      end
      WAITING: begin
        if (s_q.wait_cnt != 2'h0)
          s_d.wait_cnt = s_q.wait_cnt - 2'h1;
        else if (s_q.rdy_cfg[`RDY_HI] || sync_q[2]) begin
          s_d.ready = 1'b1;
          s_d.st = DONE;
        end
      end
      DONE: s_d.st = cyc.active ? DONE : IDLE;
      default: s_d.st = IDLE;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.upper <= `UPPER_RESET | 16'(`READY_RESET);
      s_q.sel_n <= 13'h1FFF;
      s_q.st <= IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign upper_mem_select_n = s_q.sel_n[12];
  assign lower_mem_select_n = s_q.sel_n[11];
  assign midrange_selects_n = s_q.sel_n[10:7];
  assign periph_select_n = s_q.sel_n[6:0];
  assign ready_out = s_q.ready;
  assign coproc_error_seen = sync_q[1];
  assign coproc_request = sync_q[0];

endmodule // chip_select_ready_unit

// ===== src/csr_unit_map.svh
// Offsets, field positions and reset values of the select/ready unit
`ifndef CSR_UNIT_MAP_SVH
`define CSR_UNIT_MAP_SVH
// Register indices on the plain port
`define REG_UPPER 3'h0
`define REG_LOWER 3'h1
`define REG_PERIPH_BASE 3'h2
`define REG_MID_BASE 3'h3
`define REG_MID_PERIPH 3'h4
`define REG_MODE 3'h5
// Reset: top 1 Kbyte (mask of 1K blocks), 3 waits + external ready
`define UPPER_RESET 16'hFFC0
`define READY_RESET 3'h3
// Field positions
`define RDY_HI 2
`define RDY_LO 0
// Block mask sits above the ready bits so the two never share a bit
`define MASK_HI 15
`define MASK_LO 6
`define MP_OPT 7
`define MP_MEMSP 6
`define MODE_ENH 0
// Fixed geometry
`define PERIPH_SHIFT 7
`define CTRL_BLOCK_HI 12'hFFF
`define COPROC_PORT_HI 13'h001F
`endif

// ===== src/csr_unit_pkg.sv
// Types shared by the select/ready unit
package csr_unit_pkg;
  typedef struct packed {
    logic [19:0] addr;
    logic mem_space;
    logic start;
    logic active;
    logic external;
    logic numerics;
  } bus_cycle_t;
  typedef enum logic [1:0] {
    IDLE,
    WAITING,
    DONE
  } ready_state_t;
  typedef struct packed {
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] periph_base;
    logic [15:0] mid_base;
    logic [15:0] mid_periph;
    logic enhanced;
    logic lower_seen;
    logic pbase_seen;
    logic mbase_seen;
    logic mperiph_seen;
    logic [12:0] sel_n;
    logic [1:0] addr_lat;
    logic [2:0] rdy_cfg;
    logic [1:0] wait_cnt;
    ready_state_t st;
    logic ready;
    logic [15:0] rdata;
    logic ctrl_hit;
  } unit_state_t;
endpackage

// ===== testbench/csr_unit_asserts.sv
// Port checks for the select/ready unit
`timescale 1ns/1ps
module csr_unit_checker
  import csr_unit_pkg::*;
#(
  parameter int MID_LOW_BIT = 13
) (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire bus_cycle_t cyc, // Bus cycle
  input wire logic ext_ready_pin, // External ready
  input wire logic upper_mem_select_n, // Upper select
  input wire logic lower_mem_select_n, // Lower select
  input wire logic [3:0] midrange_selects_n, // Mid selects
  input wire logic [6:0] periph_select_n, // Periph selects
  input wire logic ready_out // Internal ready
);
  logic quiet;
  logic top_hit;
  // Sixth/seventh may carry address bits, so left out
  assign quiet = &{upper_mem_select_n, lower_mem_select_n,
    midrange_selects_n[2], periph_select_n[4:0]};
  assign top_hit = cyc.start && cyc.mem_space && !cyc.external
    && &cyc.addr[19:10];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ext_quiet_a:
    assert property (cyc.active && cyc.external |=> quiet)
    else $error("select on external cycle");
  idle_quiet_a:
    assert property (!cyc.active |=> quiet)
    else $error("select low with no cycle");
  top_select_a:
    assert property (top_hit |=> !upper_mem_select_n)
    else $error("top 1K not selected");
  top_waits_a:
    assert property (top_hit |=> !ready_out [*3])
    else $error("ready before three waits");
  top_ready_a:
    assert property (top_hit |-> ##[4:40] ready_out)
    else $error("top cycle never ready");
  ext_gate_a:
    assert property ((!ext_ready_pin) [*4] ##0 !upper_mem_select_n
      |-> !ready_out)
    else $error("ready without external ready");
  rdy_pulse_a:
    assert property (ready_out |=> !ready_out)
    else $error("ready longer than one cycle");
  rdy_cause_a:
    assert property (ready_out |-> $past(cyc.active)
      && !$past(cyc.external))
    else $error("ready without own cycle");
endmodule // csr_unit_checker
bind chip_select_ready_unit csr_unit_checker #(.MID_LOW_BIT(MID_LOW_BIT))
  chk (.clk, .rst, .cyc, .ext_ready_pin, .upper_mem_select_n,
  .lower_mem_select_n, .midrange_selects_n, .periph_select_n, .ready_out);

// ===== testbench/bus_ready_responder.sv
// Ready source standing for the bus devices
`timescale 1ns/1ps
module bus_ready_responder (
  input wire logic clk, // Bus clock
  input wire logic rst, // Reset, active high
  input wire logic sel_n, // Low when any select but the sixth/seventh periph select is low
  input wire logic [3:0] lag, // Ready delay, F never
  output logic ext_ready_pin // Ready to the unit
);
  logic [3:0] cnt_q;
  logic tog_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      tog_q <= 1'b0;
    end else begin
      tog_q <= ~tog_q;
      cnt_q <= sel_n ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hF};
    end
  end
  // Released line: changing level, never a stale one
  assign ext_ready_pin = sel_n ? tog_q
    : (lag != 4'hF && cnt_q >= lag);
endmodule // bus_ready_responder

// ===== testbench/testbench.sv
// Register and bus cycle tests of the select/ready unit
`timescale 1ns/1ps
module testbench;
  import csr_unit_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  bus_cycle_t cyc = '0;
  logic [3:0] lag = 4'h2;
  logic ext_ready_pin, ready_out, upper_mem_select_n, lower_mem_select_n;
  logic [3:0] midrange_selects_n;
  logic [6:0] periph_select_n;
  logic [12:0] sel;
  logic [1:0] cp_pins = 2'h0;
  logic [1:0] cp_seen;
  int miscompares = 0;
  int n_checks = 0;
  assign sel = {upper_mem_select_n, lower_mem_select_n,
    midrange_selects_n, periph_select_n};
  always #5 clk = ~clk;
  chip_select_ready_unit uut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .cyc, .ext_ready_pin,
    .coproc_error_pin(cp_pins[1]), .coproc_request_pin(cp_pins[0]),
    .upper_mem_select_n, .lower_mem_select_n,
    .midrange_selects_n, .periph_select_n, .coproc_error_seen(cp_seen[1]),
    .coproc_request(cp_seen[0]), .ready_out);
  bus_ready_responder dev (.clk, .rst, .lag, .ext_ready_pin,
    .sel_n(&{sel[12:7], sel[4:0]}));
  // ********
  // Tasks
  // ********
  task automatic check(string w, logic [15:0] s, logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic reg_write(logic [2:0] a, logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Holds the cycle until ready is taken, or a bounded wait ends
  task automatic bus_cycle(logic [19:0] a, logic mem, logic ext,
      logic [12:0] xs, logic xr);
    logic got;
    got = 1'b0;
    @(posedge clk);
    cyc <= '{a, mem, 1'b1, 1'b1, ext, 1'b0};
    @(posedge clk);
    cyc.start <= 1'b0;
    #1 check("selects", {3'h0, sel}, {3'h0, xs});
    for (int n = 0; n < (xr ? 40 : 8) && !got; n++) begin
      got = (ready_out === 1'b1);
      if (!got) @(posedge clk);
      if (!got) #1;
    end
    check("ready", {15'h0, got}, {15'h0, xr});
    @(posedge clk);
    cyc <= '0;
  endtask
  task automatic end_sim();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ********
  // Sequence
  // ********
  initial begin
    logic [15:0] d;
    logic [12:0] xs;
    logic [19:0] pa;
    repeat (11) @(posedge clk);
    #1 check("reset", {3'h0, sel}, 16'h1FFF);
    @(posedge clk);
    rst <= 1'b0;
    bus_cycle(20'hFFC00, 1'b1, 1'b0, 13'h0FFF, 1'b1);
    lag <= 4'h9;
    bus_cycle(20'hFFFFE, 1'b1, 1'b0, 13'h0FFF, 1'b1);
    bus_cycle(20'hFFBFE, 1'b1, 1'b0, 13'h1FFF, 1'b0);
    bus_cycle(20'hFFC00, 1'b1, 1'b1, 13'h1FFF, 1'b0);
    bus_cycle(20'h00800, 1'b1, 1'b0, 13'h1FFF, 1'b0);
    reg_write(3'h1, 16'h00C4);
    lag <= 4'hF;
    bus_cycle(20'h00800, 1'b1, 1'b0, 13'h17FF, 1'b1);
    reg_write(3'h2, 16'h0044);
    bus_cycle(20'h00410, 1'b0, 1'b0, 13'h1FFF, 1'b0);
    reg_write(3'h4, 16'h0000);
    for (int k = 0; k < 7; k++) begin
      xs = 13'h1F80 | {6'h00, 7'h7F ^ (7'h01 << k)};
      pa = 20'h00410 + 20'h80 * 20'(k);
      bus_cycle(pa, 1'b0, 1'b0, xs, 1'b1);
    end
    reg_write(3'h4, 16'h0080);
    bus_cycle(20'h00402, 1'b0, 1'b0, 13'h1FBE, 1'b1);
    reg_read(3'h0, d);
    check("upper", d, 16'hFFC3);
    reg_write(3'h4, 16'h0100);
    bus_cycle(20'h01800, 1'b1, 1'b0, 13'h1FFF, 1'b0);
    reg_read(3'h3, d);
    check("mid base", d, 16'h0000);
    lag <= 4'h1;
    bus_cycle(20'h01800, 1'b1, 1'b0, 13'h1BFF, 1'b1);
    reg_write(3'h3, 16'h0004);
    bus_cycle(20'h00000, 1'b1, 1'b0, 13'h177F, 1'b1);
    reg_write(3'h5, 16'h0001);
    bus_cycle(20'h01000, 1'b1, 1'b0, 13'h1DFF, 1'b1);
    bus_cycle(20'h01800, 1'b1, 1'b0, 13'h1FFF, 1'b1);
    cp_pins <= 2'h3;
    repeat (3) @(posedge clk);
    #1 check("coproc pins", {14'h0000, cp_seen}, 16'h0003);
    reg_write(3'h6, 16'hFFFF);
    reg_read(3'h6, d);
    check("unmapped", d, 16'h0000);
    end_sim();
  end
endmodule // testbench
